/* sgt_defs.svh */
// constants for the split capable general timer
// assumes inclusion by bare name from the package and the modules
`ifndef SGT_DEFS_SVH
`define SGT_DEFS_SVH

// ****************************************
// widths and reset values
// ****************************************
`define SGT_CNT_W 32
`define SGT_HALF_W 16
`define SGT_PRESC_W 4
`define SGT_PRESC_CNT_W 16
`define SGT_CNT_RST 32'h00000000
`define SGT_HALF_RST 16'h0000
`define SGT_HALF_ONE 16'h0001
`define SGT_CNT_ONE 32'h00000001
`define SGT_PRESC_RST 16'h0000
`define SGT_PRESC_ONE 16'h0001
`define SGT_PIN_IDLE 1'b1

// ****************************************
// field positions inside the 32-bit words
// ****************************************
`define SGT_LO_MSB 15
`define SGT_LO_LSB 0
`define SGT_HI_MSB 31
`define SGT_HI_LSB 16

`endif

/* sgt_pkg.sv */
// types shared by the split capable general timer modules
// assumes sgt_defs.svh is on the include path
`include "sgt_defs.svh"

package sgt_pkg;

    // ****************************************
    // pin input function and half-timer state
    // ****************************************
    typedef enum logic [1:0] {SGT_IN_COUNT, SGT_IN_GATE, SGT_IN_CAPTURE} sgt_in_mode_t;
    typedef enum logic {SGT_IDLE, SGT_RUN} sgt_run_t;

endpackage : sgt_pkg

/* sgt_prescaler.sv */
// power-of-two prescaler producing one advance tick per 2^sel source events
// assumes a single clock and synchronous active-high reset
`include "sgt_defs.svh"

module sgt_prescaler
    import sgt_pkg::*;
#(
    parameter int PRESC_W = `SGT_PRESC_W,
    parameter int CNT_W = `SGT_PRESC_CNT_W
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_advance,
    input wire logic [PRESC_W-1:0] i_div_sel,
    output logic o_tick
);

    // ****************************************
    // divider
    // ****************************************
    function automatic logic [CNT_W-1:0] sgt_div_mask(input logic [PRESC_W-1:0] sel);
        logic [CNT_W-1:0] m;
        m = (`SGT_PRESC_ONE << sel) - `SGT_PRESC_ONE;
        return m;
    endfunction : sgt_div_mask

    logic [CNT_W-1:0] div_q;
    logic [CNT_W-1:0] div_d;
    wire at_end = (div_q & sgt_div_mask(i_div_sel)) == sgt_div_mask(i_div_sel);

    assign o_tick = i_run && i_advance && at_end;
    // counter is cleared while stopped so each run starts on a whole period
    assign div_d = !i_run ? `SGT_PRESC_RST :
                   !i_advance ? div_q :
                   at_end ? `SGT_PRESC_RST :
                   div_q + `SGT_PRESC_ONE;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            div_q <= `SGT_PRESC_RST;
        else
            div_q <= div_d;
    end

endmodule : sgt_prescaler

/* sgt_timer.sv */
// split capable general timer: 32-bit up-counter or two 16-bit halves
// assumes synchronous pin input and control inputs held by software
// Summary of operation
// - split mode gives two separate 16-bit timers
// - capture, compare, pin, pwm only in 32-bit
// - one-shot stops at terminal; continuous wraps to zero and keeps counting
// - programmable prescaler divides input before counting
// - one pin, software picks input or output
// - output pin drives pwm or rollover signal
// - input pin counts, gates or triggers capture
`include "sgt_defs.svh"

module sgt_timer
    import sgt_pkg::*;
#(
    parameter int CNT_W = `SGT_CNT_W,
    parameter int HALF_W = `SGT_HALF_W,
    parameter int PRESC_W = `SGT_PRESC_W
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_split,
    input wire logic i_continuous,
    input wire logic i_start_lo,
    input wire logic i_stop_lo,
    input wire logic i_start_hi,
    input wire logic i_stop_hi,
    input wire logic [PRESC_W-1:0] i_presc_lo,
    input wire logic [PRESC_W-1:0] i_presc_hi,
    input wire logic [CNT_W-1:0] i_reload,
    input wire logic [CNT_W-1:0] i_compare,
    input wire logic i_pin_is_out,
    input wire logic i_out_rollover,
    input wire sgt_in_mode_t i_in_mode,
    input wire logic i_pin,
    input wire logic i_flag_clr_lo,
    input wire logic i_flag_clr_hi,
    output logic o_pin,
    output logic o_pin_oe_n,
    output logic [CNT_W-1:0] o_count,
    output logic [CNT_W-1:0] o_capture,
    output logic o_running_lo,
    output logic o_running_hi,
    output logic o_flag_lo,
    output logic o_flag_hi,
    output logic o_irq
);

    // ****************************************
    // state
    // ****************************************
    sgt_run_t run_lo_q;
    sgt_run_t run_lo_d;
    sgt_run_t run_hi_q;
    sgt_run_t run_hi_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] capture_q;
    logic [CNT_W-1:0] capture_d;
    logic pin_s_q;
    logic pin_prev_q;
    logic pin_out_q;
    logic pin_out_d;
    logic pin_oe_n_q;
    logic roll_q;
    logic roll_d;
    logic flag_lo_q;
    logic flag_lo_d;
    logic flag_hi_q;
    logic flag_hi_d;
    logic irq_q;

    // ****************************************
    // pin function decode
    // ****************************************
    wire full_mode = !i_split;
    wire pin_out_en = full_mode && i_pin_is_out;
    wire pin_in_en = full_mode && !i_pin_is_out;
    // single-sample edge detect is enough only for slow pin toggling
    wire pin_rise = pin_s_q && !pin_prev_q;
    wire in_count = pin_in_en && (i_in_mode == SGT_IN_COUNT);
    wire in_gate = pin_in_en && (i_in_mode == SGT_IN_GATE);
    wire in_capture = pin_in_en && (i_in_mode == SGT_IN_CAPTURE);
    wire advance_lo = in_count ? pin_rise : in_gate ? pin_s_q : 1'b1;
    wire is_run_lo = (run_lo_q == SGT_RUN);
    wire is_run_hi = (run_hi_q == SGT_RUN) && i_split;

    // ****************************************
    // prescalers, one per half
    // ****************************************
    logic tick_lo;
    logic tick_hi;

    sgt_prescaler #(.PRESC_W(PRESC_W)) u_presc_lo
    (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_run(is_run_lo),
        .i_advance(advance_lo),
        .i_div_sel(i_presc_lo),
        .o_tick(tick_lo)
    );

    sgt_prescaler #(.PRESC_W(PRESC_W)) u_presc_hi
    (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_run(is_run_hi),
        .i_advance(1'b1),
        .i_div_sel(i_presc_hi),
        .o_tick(tick_hi)
    );

    // ****************************************
    // terminal, compare and capture events
    // ****************************************
    wire [HALF_W-1:0] cnt_lo = count_q[`SGT_LO_MSB:`SGT_LO_LSB];
    wire [HALF_W-1:0] cnt_hi = count_q[`SGT_HI_MSB:`SGT_HI_LSB];
    wire term_full = full_mode && tick_lo && (count_q == i_reload);
    wire term_lo = i_split && tick_lo && (cnt_lo == i_reload[`SGT_LO_MSB:`SGT_LO_LSB]);
    wire term_hi = is_run_hi && tick_hi && (cnt_hi == i_reload[`SGT_HI_MSB:`SGT_HI_LSB]);
    wire cmp_hit = full_mode && tick_lo && (count_q == i_compare);
    wire cap_hit = in_capture && is_run_lo && pin_rise;
    wire term_a = term_full || term_lo;

    wire [CNT_W-1:0] inc_full = count_q + `SGT_CNT_ONE;
    wire [HALF_W-1:0] inc_lo = cnt_lo + `SGT_HALF_ONE;
    wire [HALF_W-1:0] inc_hi = cnt_hi + `SGT_HALF_ONE;
    wire [HALF_W-1:0] next_lo = (i_start_lo || term_lo) ? `SGT_HALF_RST :
                                tick_lo ? inc_lo : cnt_lo;
    wire [HALF_W-1:0] next_hi = (i_start_hi || term_hi) ? `SGT_HALF_RST :
                                tick_hi ? inc_hi : cnt_hi;
    wire [CNT_W-1:0] next_full = (i_start_lo || term_full) ? `SGT_CNT_RST :
                                 tick_lo ? inc_full : count_q;

    assign count_d = i_split ? {next_hi, next_lo} : next_full;
    assign capture_d = cap_hit ? count_q : capture_q;

    // ****************************************
    // run control
    // ****************************************
    always_comb
    begin
        run_lo_d = run_lo_q;
        case (run_lo_q)
            SGT_IDLE:
                if (i_start_lo)
                    run_lo_d = SGT_RUN;
            SGT_RUN:
                if (i_stop_lo || (term_a && !i_continuous))
                    run_lo_d = SGT_IDLE;
            default:
                run_lo_d = SGT_IDLE;
        endcase
    end

    always_comb
    begin
        run_hi_d = run_hi_q;
        case (run_hi_q)
            SGT_IDLE:
                if (i_start_hi && i_split)
                    run_hi_d = SGT_RUN;
            SGT_RUN:
                if (i_stop_hi || !i_split || (term_hi && !i_continuous))
                    run_hi_d = SGT_IDLE;
            default:
                run_hi_d = SGT_IDLE;
        endcase
    end

    // ****************************************
    // pin output
    // ****************************************
    // pwm is high while the count sits below compare
    assign roll_d = term_full ? !roll_q : roll_q;
    assign pin_out_d = !pin_out_en ? 1'b0 :
                       i_out_rollover ? roll_d :
                       (next_full < i_compare);

    // ****************************************
    // sticky flags, set beats clear
    // ****************************************
    assign flag_lo_d = (term_a || cmp_hit || cap_hit) ? 1'b1 :
                       i_flag_clr_lo ? 1'b0 : flag_lo_q;
    assign flag_hi_d = term_hi ? 1'b1 : i_flag_clr_hi ? 1'b0 : flag_hi_q;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            run_lo_q <= SGT_IDLE;
            run_hi_q <= SGT_IDLE;
            count_q <= `SGT_CNT_RST;
            capture_q <= `SGT_CNT_RST;
            // pin rests high on its pull-up, so no false rise after reset
            pin_s_q <= `SGT_PIN_IDLE;
            pin_prev_q <= `SGT_PIN_IDLE;
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
            roll_q <= 1'b0;
            flag_lo_q <= 1'b0;
            flag_hi_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            run_lo_q <= run_lo_d;
            run_hi_q <= run_hi_d;
            count_q <= count_d;
            capture_q <= capture_d;
            pin_s_q <= i_pin;
            pin_prev_q <= pin_s_q;
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= !pin_out_en;
            roll_q <= roll_d;
            flag_lo_q <= flag_lo_d;
            flag_hi_q <= flag_hi_d;
            irq_q <= flag_lo_d || flag_hi_d;
        end
    end

    assign o_pin = pin_out_q;
    assign o_pin_oe_n = pin_oe_n_q;
    assign o_count = count_q;
    assign o_capture = capture_q;
    assign o_running_lo = (run_lo_q == SGT_RUN);
    assign o_running_hi = (run_hi_q == SGT_RUN);
    assign o_flag_lo = flag_lo_q;
    assign o_flag_hi = flag_hi_q;
    assign o_irq = irq_q;

endmodule : sgt_timer

/* sgt_timer_sva.sv */
// checker: port relations of sgt_timer
// assumes the clock is the count source while the pin is an output
module sgt_timer_sva #(parameter int CNT_W = 32, parameter int PRESC_W = 4)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_split,
    input wire logic i_continuous,
    input wire logic i_start_lo,
    input wire logic i_stop_lo,
    input wire logic i_start_hi,
    input wire logic [PRESC_W-1:0] i_presc_lo,
    input wire logic [CNT_W-1:0] i_reload,
    input wire logic [CNT_W-1:0] i_compare,
    input wire logic i_pin_is_out,
    input wire logic i_out_rollover,
    input wire logic i_flag_clr_lo,
    input wire logic o_pin,
    input wire logic o_pin_oe_n,
    input wire logic [CNT_W-1:0] o_count,
    input wire logic o_running_lo,
    input wire logic o_running_hi,
    input wire logic o_flag_lo,
    input wire logic o_flag_hi,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // undivided 32-bit clock count
    // ****************************************
    wire run32 = !i_split && i_pin_is_out && i_presc_lo == {PRESC_W{1'b0}} && o_running_lo
        && !i_start_lo && !i_stop_lo;
    wire at_end = run32 && o_count == i_reload;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_split_pin_off: assert property (i_split && $past(i_split) |-> o_pin_oe_n)
        else $error("pin driven while split");
    a_start_clears: assert property (i_start_lo && !i_stop_lo |=> o_running_lo
        && o_count[15:0] == 16'h0) else $error("start did not clear");
    a_count_step: assert property (run32 && o_count != i_reload
        |=> o_count == $past(o_count) + 32'h1) else $error("count step wrong");
    a_wrap_zero: assert property (at_end |=> o_count == 32'h0 && o_flag_lo
        && o_running_lo == i_continuous) else $error("terminal wrong");
    a_roll_toggle: assert property (at_end && i_out_rollover && i_continuous
        |=> o_pin != $past(o_pin)) else $error("rollover missed");
    a_pwm_level: assert property (!i_split && i_pin_is_out && !i_out_rollover
        && o_running_lo && $past(o_running_lo) |-> o_pin == (o_count < i_compare))
        else $error("pwm level wrong");
    a_flag_hold: assert property (o_flag_lo && !i_flag_clr_lo |=> o_flag_lo)
        else $error("flag lost");
    a_irq_or: assert property (o_irq == (o_flag_lo || o_flag_hi))
        else $error("irq mismatch");
    a_hi_still: assert property (i_split && !o_running_hi && !i_start_hi
        |=> !i_split || $stable(o_count[31:16])) else $error("idle half moved");
endmodule : sgt_timer_sva

bind sgt_timer sgt_timer_sva #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) u_sgt_timer_sva (.*);

/* sgt_pin_model.sv */
// external signal on the timer pin
// assumes a weak pull-up when nobody drives the line
module sgt_pin_model
(
    input wire logic i_clk_sys,
    input wire logic i_drv_val,
    input wire logic i_drv_oe_n,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_en = 1'b0;
    logic drv = 1'b0;
    assign o_line = !i_drv_oe_n ? i_drv_val : (drv_en ? drv : 1'b1);
    // callers hold each level two cycles at least: clk/4 limit
    task automatic drive(input logic v, input int n);
        drv_en = 1'b1;
        drv = v;
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : drive
endmodule : sgt_pin_model

/* sgt_timer_tb.sv */
// testbench for sgt_timer: modes, split, pin functions
// assumes the pin model stands on the timer pin
module sgt_timer_tb;
    import sgt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, i_split = 1'b0, i_continuous = 1'b0;
    logic i_start_lo = 1'b0, i_stop_lo = 1'b0, i_start_hi = 1'b0, i_stop_hi = 1'b0;
    logic i_pin_is_out = 1'b1, i_out_rollover = 1'b0, i_pin;
    logic i_flag_clr_lo = 1'b0, i_flag_clr_hi = 1'b0;
    logic [3:0] i_presc_lo = 4'h0, i_presc_hi = 4'h0;
    logic [31:0] i_reload = 32'h2, i_compare = 32'h10, c, o_count, o_capture;
    sgt_in_mode_t i_in_mode = SGT_IN_COUNT;
    logic o_pin, o_pin_oe_n, o_running_lo, o_running_hi, o_flag_lo, o_flag_hi, o_irq;
    int n_fail = 0, num_checks = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    sgt_timer u_sgt_timer (.*);
    sgt_pin_model u_sgt_pin_model (.i_clk_sys(i_clk_sys), .i_drv_val(o_pin),
        .i_drv_oe_n(o_pin_oe_n), .o_line(i_pin));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic test_done();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_modes();
        pulse(i_start_lo);
        for (int k = 0; k < 3; k++)
        begin
            chk({o_running_lo, o_count}, {1'b1, 32'(k)});
            cyc(1);
        end
        cyc(2);
        chk({o_running_lo, o_flag_lo, o_irq, o_count}, {3'b011, 32'h0});
        pulse(i_flag_clr_lo);
        chk({o_flag_lo, o_irq}, 2'b00);
        i_continuous = 1'b1;
        i_out_rollover = 1'b1;
        pulse(i_start_lo);
        c[0] = o_pin;
        for (int k = 0; k < 9; k++)
        begin
            chk({o_pin, o_count}, {c[0] ^ ((k / 3) % 2 == 1), k % 3});
            cyc(1);
        end
        pulse(i_stop_lo);
        c = o_count;
        cyc(3);
        chk({o_running_lo, o_count}, {1'b0, c});
    endtask : t_modes
    task automatic t_pwm_presc();
        i_out_rollover = 1'b0;
        i_reload = 32'h3;
        i_compare = 32'h2;
        pulse(i_flag_clr_lo);
        pulse(i_start_lo);
        for (int k = 0; k < 8; k++)
        begin
            chk({o_flag_lo, o_pin, o_count}, {k >= 3, k % 4 < 2, k % 4});
            cyc(1);
        end
        pulse(i_stop_lo);
        i_presc_lo = 4'h2;
        i_reload = 32'hff;
        pulse(i_start_lo);
        for (int n = 0; n < 40 && o_count !== 32'h1; n++)
            cyc(1);
        chk(o_count, 32'h1);
        // a wait that ran out goes straight to the report
        if (o_count !== 32'h1)
            test_done();
        cyc(4);
        chk(o_count, 32'h2);
        cyc(4);
        chk(o_count, 32'h3);
        pulse(i_stop_lo);
        i_presc_lo = 4'h0;
    endtask : t_pwm_presc
    task automatic t_split();
        // lo wraps at 2 only if the halves are truly separate
        i_split = 1'b1;
        i_reload = {16'h5, 16'h2};
        pulse(i_start_lo);
        for (int k = 0; k < 6; k++)
        begin
            chk({o_pin_oe_n, o_count}, {1'b1, 16'h0, 16'(k % 3)});
            cyc(1);
        end
        pulse(i_start_hi);
        for (int k = 0; k < 7; k++)
        begin
            chk({o_running_hi, o_count[31:16]}, {1'b1, 16'(k % 6)});
            cyc(1);
        end
        chk({o_flag_hi, o_irq}, 2'b11);
        pulse(i_flag_clr_hi);
        pulse(i_stop_hi);
        chk({o_flag_hi, o_running_hi}, 2'b00);
        pulse(i_stop_lo);
        i_split = 1'b0;
    endtask : t_split
    task automatic t_pin();
        i_pin_is_out = 1'b0;
        u_sgt_pin_model.drive(1'b0, 3);
        pulse(i_start_lo);
        for (int k = 0; k < 3; k++)
        begin
            u_sgt_pin_model.drive(1'b1, 2);
            u_sgt_pin_model.drive(1'b0, 2);
        end
        cyc(3);
        chk({o_pin_oe_n, o_count}, {1'b1, 32'h3});
        i_in_mode = SGT_IN_GATE;
        u_sgt_pin_model.drive(1'b0, 4);
        c = o_count;
        u_sgt_pin_model.drive(1'b0, 4);
        chk(o_count, c);
        u_sgt_pin_model.drive(1'b1, 4);
        c = o_count;
        u_sgt_pin_model.drive(1'b1, 5);
        chk(o_count, c + 32'h5);
        i_in_mode = SGT_IN_CAPTURE;
        u_sgt_pin_model.drive(1'b0, 3);
        pulse(i_flag_clr_lo);
        c = o_count;
        u_sgt_pin_model.drive(1'b1, 4);
        chk({o_flag_lo, o_irq, o_capture > c && o_capture < c + 32'h6}, 3'b111);
    endtask : t_pin
    initial
    begin
        cyc(4);
        i_reset = 1'b0;
        chk({o_pin_oe_n, o_running_lo, o_flag_lo, o_count}, {3'b100, 32'h0});
        t_modes();
        t_pwm_presc();
        t_split();
        t_pin();
        test_done();
    end
endmodule : sgt_timer_tb
